// file: inc/adc_record_path_map.vh
// constants and register map of the record path processing block
// Operation
// - high-pass enable bit 8 bypasses filter when clear; resets to one.
// - audio mode runs a first-order high-pass near 3.7 Hz.
// - application mode runs second-order high-pass, corner from code bits 6:4.
// - cutoff codes span 82 to 408 Hz; valid only with correct rate code; code gives only three corners (shift 4, 3, 2), rate code unused.
// - two 14-bit notch coefficients split high/low over four registers; enable bit 7.
// - coefficients reach working copy only when bit 8 written high.
// - digital gain code X gives 0.5*(X-255) dB, zero mutes, default all ones.
// - limiter style lowers gain on peaks, restores slowly, never above static level.
// - level style keeps recorded peak level at target by steering preamp gain.
// - gain loop runs only while enable bit 8 is set; default off.
// - target code 0000 is -28.5 dBFS, 1.5 dB steps, default 1011.
// - gain ceiling code 111 is +35.25 dB, 6 dB per code lower.
// - gain floor code 000 is -12 dB, 6 dB per code higher.
// - hold before raising gain doubles per code from 2.67 ms; zero for 0000.
// - level style decay from 3.3 ms per 6 dB, doubling, capped at code 1010.
// - level style attack from 832 us per 6 dB, doubling, capped at code 1010.
// - limiter style steps about 4.5 times faster and ignores hold time.
// - all loop times count samples at the programmed rate.
// - above 87.5% full scale the loop attacks at the fastest rate.
// - noise gate blocks gain rises while input-referred level is below threshold.
// - gate threshold 000 is -39 dBFS, falling 6 dB per code.
// - noise gate acts only while gate enable bit 3 is set.
// - while loop is on it drives preamp gain, not the manual code.
`ifndef ADC_RECORD_PATH_MAP_VH
`define ADC_RECORD_PATH_MAP_VH

`define ADDR_RECORD_FILTER_CONTROL 7'h0E
`define ADDR_RECORD_DIGITAL_VOLUME 7'h0F
`define ADDR_NOTCH_COEF0_HIGH      7'h1B
`define ADDR_NOTCH_COEF0_LOW       7'h1C
`define ADDR_NOTCH_COEF1_HIGH      7'h1D
`define ADDR_NOTCH_COEF1_LOW       7'h1E
`define ADDR_GAIN_LOOP_CONTROL_ONE 7'h20
`define ADDR_GAIN_LOOP_CONTROL_TWO 7'h21
`define ADDR_GAIN_LOOP_CONTROL_THR 7'h22
`define ADDR_NOISE_GATE_CONTROL    7'h23
`define ADDR_PREAMP_GAIN_CONTROL   7'h2D

`define RST_FILTER_CONTROL 9'h100
`define RST_DIGITAL_VOLUME 8'hFF
`define RST_LOOP_ONE       9'h038
`define RST_LOOP_TWO       9'h00B
`define RST_LOOP_THREE     9'h032
`define RST_GATE           4'h0
`define RST_PREAMP         8'h10

`define HPF_ON_BIT   8
`define HPF_APP_BIT  7
`define HPF_CUT_MSB  6
`define HPF_CUT_LSB  4
`define POLARITY_BIT 0
`define NOTCH_ON_BIT 7
`define LATCH_BIT    8
`define COEF_MSB     6
`define LOOP_ON_BIT  8
`define CEIL_MSB     5
`define CEIL_LSB     3
`define FLOOR_MSB    2
`define FLOOR_LSB    0
`define HOLD_MSB     7
`define HOLD_LSB     4
`define TGT_MSB      3
`define TGT_LSB      0
`define STYLE_BIT    8
`define DCY_MSB      7
`define DCY_LSB      4
`define ATK_MSB      3
`define ATK_LSB      0
`define GATE_ON_BIT  3
`define GATE_TH_MSB  2
`define GATE_TH_LSB  0
`define GAIN_MSB     5

// loop step times in ns, converted to eighth-samples at 48 kHz
`define ATK_STEP_NS  104000
`define DCY_STEP_NS  410000
`define LATK_STEP_NS 22700
`define LDCY_STEP_NS 90800
`define HOLD_UNIT_NS 2670000
`define E8(t) (((t) * 384 + 500000) / 1000000)
`define RATE_CODE_CAP 4'hA

// eighth-sample weight of one sample, per rate code
`define INC_R48 5'h08
`define INC_R32 5'h0C
`define INC_R24 5'h10
`define INC_R16 5'h18
`define INC_R12 5'h20
`define INC_R8  5'h30

// levels in 0.75 dB units, full scale 184
`define TGT_BASE    8'h92
`define GATE_BASE   9'h074
`define BOOST_UNITS 9'h01B
`define CLIP_MAG    24'h700000

`define HPF_AUDIO_SHIFT 4'hB
`define HPF_SHIFT_LOW   4'h4
`define HPF_SHIFT_MID   4'h3
`define HPF_SHIFT_HIGH  4'h2

`define FIFO_DEPTH 8
`define SAMPLE_W   24

`endif

// file: verilog/sample_fifo.v
// sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter W = 24,
    parameter D = 8,
    parameter A = 3
) (
    input  wire         clk_sys,   // clock
    input  wire         rstn,      // async reset, low
    input  wire [W-1:0] in_data,   // write data
    input  wire         in_valid,  // write request
    output wire         in_ready,  // space free
    output wire [W-1:0] out_data,  // head entry
    output wire         out_valid, // not empty
    input  wire         out_ready  // reader takes head
);
    reg [W-1:0] mem_q [0:D-1];
    reg [A-1:0] wp_q;
    reg [A-1:0] rp_q;
    reg [A:0]   cnt_q;
    wire        push;
    wire        pop;

    assign in_ready  = (cnt_q != D);
    assign out_valid = (cnt_q != 0);
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wp_q  <= {A{1'b0}};
            rp_q  <= {A{1'b0}};
            cnt_q <= {(A+1){1'b0}};
        end else begin
            if (push)
                wp_q <= (wp_q == D - 1) ? {A{1'b0}} : wp_q + 1'b1;
            if (pop)
                rp_q <= (rp_q == D - 1) ? {A{1'b0}} : rp_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < D; g = g + 1) begin : slot
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn)
                    mem_q[g] <= {W{1'b0}};
                else if (push && wp_q == g)
                    mem_q[g] <= in_data;
            end
        end
    endgenerate
endmodule // sample_fifo
`default_nettype wire

// file: verilog/adc_record_path_processing.v
// record path: high-pass, notch, volume and automatic gain loop
`timescale 1ns/1ps
`default_nettype none
`include "adc_record_path_map.vh"
module adc_record_path_processing (
    input  wire        clk_sys,          // system clock
    input  wire        rstn,             // async reset, low
    input  wire        reg_wr,           // register write strobe
    input  wire [6:0]  reg_addr,         // register address
    input  wire [8:0]  reg_wdata,        // register write data
    output reg  [8:0]  reg_rdata,        // read data of reg_addr
    input  wire [2:0]  sample_rate_code, // programmed rate code
    input  wire        boost_on,         // +20 dB boost stage on
    input  wire [23:0] adc_data,         // decimator sample
    input  wire        adc_valid,        // sample offered
    output wire        adc_ready,        // sample taken
    output wire [23:0] rec_data,         // processed sample
    output wire        rec_valid,        // processed sample ready
    input  wire        rec_ready,        // interface takes sample
    output reg  [5:0]  preamp_gain       // gain code to preamp
);
    localparam integer ATK0  = `E8(`ATK_STEP_NS);
    localparam integer DCY0  = `E8(`DCY_STEP_NS);
    localparam integer LATK0 = `E8(`LATK_STEP_NS);
    localparam integer LDCY0 = `E8(`LDCY_STEP_NS);
    localparam integer HOLD1 = `E8(`HOLD_UNIT_NS);

    reg  [8:0]  filt_q;
    reg  [7:0]  vol_q;
    reg  [6:0]  c0h_q;
    reg  [6:0]  c0l_q;
    reg  [6:0]  c1h_q;
    reg  [6:0]  c1l_q;
    reg         notch_on_q;
    reg  [13:0] coef0_q;
    reg  [13:0] coef1_q;
    reg  [8:0]  lc1_q;
    reg  [8:0]  lc2_q;
    reg  [8:0]  lc3_q;
    reg  [3:0]  gate_q;
    reg  [7:0]  pga_q;

    // register writes
    wire wr_filt = reg_wr && reg_addr == `ADDR_RECORD_FILTER_CONTROL;
    wire wr_vol  = reg_wr && reg_addr == `ADDR_RECORD_DIGITAL_VOLUME;
    wire wr_c0h  = reg_wr && reg_addr == `ADDR_NOTCH_COEF0_HIGH;
    wire wr_c0l  = reg_wr && reg_addr == `ADDR_NOTCH_COEF0_LOW;
    wire wr_c1h  = reg_wr && reg_addr == `ADDR_NOTCH_COEF1_HIGH;
    wire wr_c1l  = reg_wr && reg_addr == `ADDR_NOTCH_COEF1_LOW;
    wire wr_lc1  = reg_wr && reg_addr == `ADDR_GAIN_LOOP_CONTROL_ONE;
    wire wr_lc2  = reg_wr && reg_addr == `ADDR_GAIN_LOOP_CONTROL_TWO;
    wire wr_lc3  = reg_wr && reg_addr == `ADDR_GAIN_LOOP_CONTROL_THR;
    wire wr_gate = reg_wr && reg_addr == `ADDR_NOISE_GATE_CONTROL;
    wire wr_pga  = reg_wr && reg_addr == `ADDR_PREAMP_GAIN_CONTROL;

    wire [6:0] c0h_d = wr_c0h ? reg_wdata[`COEF_MSB:0] : c0h_q;
    wire [6:0] c0l_d = wr_c0l ? reg_wdata[`COEF_MSB:0] : c0l_q;
    wire [6:0] c1h_d = wr_c1h ? reg_wdata[`COEF_MSB:0] : c1h_q;
    wire [6:0] c1l_d = wr_c1l ? reg_wdata[`COEF_MSB:0] : c1l_q;
    wire notch_latch_strobe = reg_wdata[`LATCH_BIT] &&
                              (wr_c0h || wr_c0l || wr_c1h || wr_c1l);

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            filt_q     <= `RST_FILTER_CONTROL;
            vol_q      <= `RST_DIGITAL_VOLUME;
            c0h_q      <= 7'h00;
            c0l_q      <= 7'h00;
            c1h_q      <= 7'h00;
            c1l_q      <= 7'h00;
            notch_on_q <= 1'b0;
            coef0_q    <= 14'h0000;
            coef1_q    <= 14'h0000;
            lc1_q      <= `RST_LOOP_ONE;
            lc2_q      <= `RST_LOOP_TWO;
            lc3_q      <= `RST_LOOP_THREE;
            gate_q     <= `RST_GATE;
            pga_q      <= `RST_PREAMP;
        end else begin
            if (wr_filt)
                filt_q <= reg_wdata;
            if (wr_vol)
                vol_q <= reg_wdata[7:0];
            c0h_q <= c0h_d;
            c0l_q <= c0l_d;
            c1h_q <= c1h_d;
            c1l_q <= c1l_d;
            if (wr_c0h)
                notch_on_q <= reg_wdata[`NOTCH_ON_BIT];
            if (notch_latch_strobe) begin
                coef0_q <= {c0h_d, c0l_d};
                coef1_q <= {c1h_d, c1l_d};
            end
            if (wr_lc1)
                lc1_q <= reg_wdata;
            if (wr_lc2)
                lc2_q <= reg_wdata;
            if (wr_lc3)
                lc3_q <= reg_wdata;
            if (wr_gate)
                gate_q <= reg_wdata[3:0];
            if (wr_pga)
                pga_q <= reg_wdata[7:0];
        end
    end

    // readback; the latch strobe bit always reads zero
    reg [8:0] rd_mux;
    always @* begin
        case (reg_addr)
            `ADDR_RECORD_FILTER_CONTROL: rd_mux = filt_q;
            `ADDR_RECORD_DIGITAL_VOLUME: rd_mux = {1'b0, vol_q};
            `ADDR_NOTCH_COEF0_HIGH:      rd_mux = {1'b0, notch_on_q, c0h_q};
            `ADDR_NOTCH_COEF0_LOW:       rd_mux = {2'b00, c0l_q};
            `ADDR_NOTCH_COEF1_HIGH:      rd_mux = {2'b00, c1h_q};
            `ADDR_NOTCH_COEF1_LOW:       rd_mux = {2'b00, c1l_q};
            `ADDR_GAIN_LOOP_CONTROL_ONE: rd_mux = lc1_q;
            `ADDR_GAIN_LOOP_CONTROL_TWO: rd_mux = lc2_q;
            `ADDR_GAIN_LOOP_CONTROL_THR: rd_mux = lc3_q;
            `ADDR_NOISE_GATE_CONTROL:    rd_mux = {5'h00, gate_q};
            `ADDR_PREAMP_GAIN_CONTROL:   rd_mux = {1'b0, pga_q};
            default:                     rd_mux = 9'h000;
        endcase
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            reg_rdata <= 9'h000;
        else
            reg_rdata <= rd_mux;
    end

    // fields
    wire       hp_filter_on         = filt_q[`HPF_ON_BIT];
    wire       hp_filter_app_select = filt_q[`HPF_APP_BIT];
    wire [2:0] hp_cutoff_code       = filt_q[`HPF_CUT_MSB:`HPF_CUT_LSB];
    wire       record_polarity      = filt_q[`POLARITY_BIT];
    wire       level_ctl_on         = lc1_q[`LOOP_ON_BIT];
    wire [2:0] gain_ceiling         = lc1_q[`CEIL_MSB:`CEIL_LSB];
    wire [2:0] gain_floor           = lc1_q[`FLOOR_MSB:`FLOOR_LSB];
    wire [3:0] ramp_up_delay        = lc2_q[`HOLD_MSB:`HOLD_LSB];
    wire [3:0] level_target         = lc2_q[`TGT_MSB:`TGT_LSB];
    wire       level_ctl_style      = lc3_q[`STYLE_BIT];
    wire [3:0] ramp_up_rate         = lc3_q[`DCY_MSB:`DCY_LSB];
    wire [3:0] ramp_down_rate       = lc3_q[`ATK_MSB:`ATK_LSB];
    wire       gate_on              = gate_q[`GATE_ON_BIT];
    wire [2:0] gate_threshold       = gate_q[`GATE_TH_MSB:`GATE_TH_LSB];
    wire [5:0] preamp_gain_code     = pga_q[`GAIN_MSB:0];

    function [23:0] sat;
        input signed [39:0] v;
        begin
            if (v > 40'sh00007FFFFF)
                sat = 24'h7FFFFF;
            else if (v < -40'sh0000800000)
                sat = 24'h800000;
            else
                sat = v[23:0];
        end
    endfunction

    // log2 level, 3 fraction bits: 0.75 dB units
    function [7:0] lg;
        input [23:0] m;
        integer i;
        begin
            lg = 8'h00;
            for (i = 3; i < 24; i = i + 1)
                if (m[i])
                    lg = {i[4:0], m[i-1 -: 3]};
        end
    endfunction

    // 2^(-r/12) in 1.15 format, one half-dB step per r
    function [15:0] mant;
        input [3:0] r;
        begin
            case (r)
                4'h0:    mant = 16'h8000;
                4'h1:    mant = 16'h78D1;
                4'h2:    mant = 16'h7209;
                4'h3:    mant = 16'h6BA2;
                4'h4:    mant = 16'h6598;
                4'h5:    mant = 16'h5FE4;
                4'h6:    mant = 16'h5A82;
                4'h7:    mant = 16'h556E;
                4'h8:    mant = 16'h50A3;
                4'h9:    mant = 16'h4C1C;
                4'hA:    mant = 16'h47D6;
                default: mant = 16'h43CE;
            endcase
        end
    endfunction

    wire take = adc_valid && adc_ready;
    wire signed [39:0] x_ext = {{16{adc_data[23]}}, adc_data};
    wire [23:0] x0 = record_polarity ? sat(-x_ext) : adc_data;

    // high-pass: leaky dc trackers
    reg  signed [31:0] dc1_q;
    reg  signed [31:0] dc2_q;
    reg  [3:0] app_shift;
    always @* begin
        case (hp_cutoff_code)
            3'h0, 3'h1:       app_shift = `HPF_SHIFT_LOW;
            3'h2, 3'h3, 3'h4: app_shift = `HPF_SHIFT_MID;
            default:          app_shift = `HPF_SHIFT_HIGH;
        endcase
    end
    wire [3:0] hk = hp_filter_app_select ? app_shift : `HPF_AUDIO_SHIFT;
    wire signed [39:0] e1 = {{8{x0[23]}}, x0, 8'h00} -
                            {{8{dc1_q[31]}}, dc1_q};
    wire [23:0] y1 = sat(e1 >>> 8);
    wire signed [39:0] e2 = {{8{y1[23]}}, y1, 8'h00} -
                            {{8{dc2_q[31]}}, dc2_q};
    wire [23:0] y2 = sat(e2 >>> 8);
    wire signed [39:0] s1 = e1 >>> hk;
    wire signed [39:0] s2 = e2 >>> hk;
    wire [23:0] hp_out = !hp_filter_on ? x0 :
                         hp_filter_app_select ? y2 : y1;

    // notch: half of input plus allpass
    reg  signed [23:0] nx1_q;
    reg  signed [23:0] nx2_q;
    reg  signed [23:0] ny1_q;
    reg  signed [23:0] ny2_q;
    wire signed [13:0] c0s = coef0_q;
    wire signed [13:0] c1s = coef1_q;
    wire signed [24:0] d1 = {ny1_q[23], ny1_q} - {nx1_q[23], nx1_q};
    wire signed [24:0] d0 = {ny2_q[23], ny2_q} - {hp_out[23], hp_out};
    wire signed [38:0] p1 = c1s * d1;
    wire signed [38:0] p0 = c0s * d0;
    wire signed [39:0] q1 = {p1[38], p1};
    wire signed [39:0] q0 = {p0[38], p0};
    wire signed [39:0] ap_sum = {{16{nx2_q[23]}}, nx2_q} +
                                (q1 >>> 12) + (q0 >>> 13);
    wire [23:0] ap = sat(ap_sum);
    wire [24:0] nsum = {hp_out[23], hp_out} + {ap[23], ap};
    wire [23:0] nt_out = notch_on_q ? nsum[24:1] : hp_out;

    wire [7:0]  att   = 8'hFF - vol_q;
    wire [7:0]  att_q = att / 8'h0C;
    wire [7:0]  att_r = att % 8'h0C;
    wire [15:0] mv    = mant(att_r[3:0]);
    wire signed [40:0] vp = $signed(nt_out) * $signed({1'b0, mv});
    wire signed [40:0] vs = vp >>> ({1'b0, att_q[4:0]} + 6'h0F);
    wire [23:0] vol_out = (vol_q == 8'h00) ? 24'h000000 : vs[23:0];

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dc1_q <= 32'sh00000000;
            dc2_q <= 32'sh00000000;
            nx1_q <= 24'sh000000;
            nx2_q <= 24'sh000000;
            ny1_q <= 24'sh000000;
            ny2_q <= 24'sh000000;
        end else if (take) begin
            dc1_q <= dc1_q + s1[31:0];
            dc2_q <= dc2_q + s2[31:0];
            nx1_q <= hp_out;
            nx2_q <= nx1_q;
            ny1_q <= ap;
            ny2_q <= ny1_q;
        end
    end

    sample_fifo #(
        .W (`SAMPLE_W),
        .D (`FIFO_DEPTH),
        .A (3)
    ) out_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_data   (vol_out),
        .in_valid  (adc_valid),
        .in_ready  (adc_ready),
        .out_data  (rec_data),
        .out_valid (rec_valid),
        .out_ready (rec_ready)
    );

    // automatic gain loop
    reg  [7:0]  peak_q;
    reg  [25:0] acc_q;
    reg         down_q;
    reg         hold_done_q;
    reg  [4:0]  inc;
    always @* begin
        case (sample_rate_code)
            3'h1:    inc = `INC_R32;
            3'h2:    inc = `INC_R24;
            3'h3:    inc = `INC_R16;
            3'h4:    inc = `INC_R12;
            3'h5:    inc = `INC_R8;
            default: inc = `INC_R48;
        endcase
    end

    wire [23:0] mag = x0[23] ? (~x0 + 24'h000001) : x0;
    wire [7:0]  lvl = lg(mag);
    wire [7:0]  pk  = (lvl > peak_q) ? lvl : peak_q;
    wire clip = mag >= `CLIP_MAG;
    wire [7:0] tgt = `TGT_BASE + {3'h0, level_target, 1'b0};
    wire dir_down = clip || (pk > tgt);
    wire [8:0] gthr = `GATE_BASE - {3'h0, gate_threshold, 3'h0} +
                      {3'h0, preamp_gain} +
                      (boost_on ? `BOOST_UNITS : 9'h000);
    wire gated = gate_on && ({1'b0, pk} < gthr);

    wire [5:0] ceil = {gain_ceiling, 3'h7};
    wire [5:0] flr  = {gain_floor, 3'h0};
    wire [5:0] stat_lim = (preamp_gain_code < ceil) ? preamp_gain_code
                                                    : ceil;
    wire up_ok = level_ctl_style ? (preamp_gain < stat_lim)
                                 : (preamp_gain < ceil);

    wire [3:0] atk_c = (ramp_down_rate > `RATE_CODE_CAP) ?
                       `RATE_CODE_CAP : ramp_down_rate;
    wire [3:0] dcy_c = (ramp_up_rate > `RATE_CODE_CAP) ?
                       `RATE_CODE_CAP : ramp_up_rate;
    wire [25:0] atk_b = level_ctl_style ? LATK0[25:0] : ATK0[25:0];
    wire [25:0] dcy_b = level_ctl_style ? LDCY0[25:0] : DCY0[25:0];
    wire [25:0] down_per = clip ? atk_b : (atk_b << atk_c);
    wire [25:0] up_per   = dcy_b << dcy_c;
    wire [25:0] hold_per = HOLD1[25:0] << (ramp_up_delay - 4'h1);
    wire in_hold = !level_ctl_style && !dir_down && !hold_done_q &&
                   (ramp_up_delay != 4'h0);
    wire [25:0] per = dir_down ? down_per : in_hold ? hold_per : up_per;
    wire [25:0] acc_base = (dir_down != down_q) ? 26'h0000000 : acc_q;
    wire [25:0] acc_sum  = acc_base + {21'h000000, inc};
    wire step = acc_sum >= per;

    reg [5:0] gain_nx;
    always @* begin
        gain_nx = preamp_gain;
        if (dir_down) begin
            if (step && preamp_gain > flr)
                gain_nx = preamp_gain - 6'h01;
        end else if (!in_hold && step && !gated && up_ok) begin
            gain_nx = preamp_gain + 6'h01;
        end
        if (gain_nx < flr)
            gain_nx = flr;
        if (gain_nx > ceil)
            gain_nx = ceil;
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            preamp_gain <= 6'h10;
            peak_q      <= 8'h00;
            acc_q       <= 26'h0000000;
            down_q      <= 1'b0;
            hold_done_q <= 1'b0;
        end else if (!level_ctl_on) begin
            preamp_gain <= preamp_gain_code;
            peak_q      <= 8'h00;
            acc_q       <= 26'h0000000;
            down_q      <= 1'b0;
            hold_done_q <= 1'b0;
        end else if (take) begin
            preamp_gain <= gain_nx;
            down_q      <= dir_down;
            acc_q       <= step ? 26'h0000000 : acc_sum;
            peak_q      <= (step && pk != 8'h00) ? pk - 8'h01 : pk;
            if (dir_down)
                hold_done_q <= 1'b0;
            else if (in_hold && step)
                hold_done_q <= 1'b1;
        end
    end
endmodule // adc_record_path_processing
`default_nettype wire

// file: bench/adc_record_path_properties.sv
// port checker of the record path block
`timescale 1ns/1ps
`default_nettype none
module adc_record_path_properties (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        reg_wr,
    input wire logic [6:0]  reg_addr,
    input wire logic [8:0]  reg_wdata,
    input wire logic [8:0]  reg_rdata,
    input wire logic        adc_valid,
    input wire logic        adc_ready,
    input wire logic [23:0] rec_data,
    input wire logic        rec_valid,
    input wire logic        rec_ready,
    input wire logic [5:0]  preamp_gain
);
    logic [8:0] r1_q;
    logic [7:0] vol_q;
    logic [3:0] cnt_q;
    wire tk = adc_valid && adc_ready;
    wire on = r1_q[8];
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r1_q  <= 9'h038;
            vol_q <= 8'hFF;
            cnt_q <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == 7'h20) r1_q <= reg_wdata;
            if (reg_wr && reg_addr == 7'h0F) vol_q <= reg_wdata[7:0];
            cnt_q <= cnt_q + 4'(tk) - 4'(rec_valid && rec_ready);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_fifo_ready: assert property (adc_ready == (cnt_q != 4'h8))
        else $error("ready does not follow fill");
    chk_fifo_valid: assert property (rec_valid == (cnt_q != 4'h0))
        else $error("valid does not follow fill");
    chk_out_stands: assert property (rec_valid && !rec_ready
        |=> rec_valid && $stable(rec_data)) else $error("output moved");
    chk_mute_zero: assert property (tk && cnt_q == 0 && vol_q == 0
        |=> rec_data == 24'h0) else $error("mute passed data");
    chk_latch_reads: assert property (reg_addr inside {[7'h1B:7'h1E]}
        |=> !reg_rdata[8]) else $error("latch bit read back");
    chk_gain_ceiling: assert property (tk && on
        |=> preamp_gain <= {r1_q[5:3], 3'h7}) else $error("above ceiling");
    chk_gain_floor: assert property (tk && on |=>
        preamp_gain >= {r1_q[2:0], 3'h0} || r1_q[2:0] > r1_q[5:3])
        else $error("below floor");
    chk_off_holds: assert property (!on && !reg_wr && !$past(reg_wr)
        |=> $stable(preamp_gain)) else $error("gain moved, loop off");
    chk_idle_holds: assert property (on && !tk && !$past(reg_wr)
        |=> $stable(preamp_gain)) else $error("gain moved, no sample");
    cover property (!adc_ready);
    cover property (tk && on);
    cover property (tk && vol_q == 0 && cnt_q == 0);
endmodule // adc_record_path_properties
bind adc_record_path_processing adc_record_path_properties u_chk (.*);
`default_nettype wire

// file: bench/adc_source.sv
// decimator stand-in offering record samples
`timescale 1ns/1ps
`default_nettype none
module adc_source (
    input  wire logic        clk_sys,   // clock
    input  wire logic        go,        // offer samples
    input  wire logic [23:0] amp,       // sample value
    input  wire logic        alt,       // alternate sign
    input  wire logic        adc_ready, // design takes
    output var  logic [23:0] adc_data,  // sample
    output var  logic        adc_valid  // sample offered
);
    logic neg = 1'b0;
    logic took = 1'b0;
    logic go_s = 1'b0, alt_s = 1'b0;
    logic [23:0] amp_s = 24'h0;
    // controls taken at the rising edge, clear of the bench's falling edge
    always @(posedge clk_sys) {go_s, alt_s, amp_s} <= {go, alt, amp};
    initial adc_valid = 1'b0;
    initial adc_data = 24'h0;
    always @(posedge clk_sys) took <= adc_valid && adc_ready;
    // held until taken; idle data keeps toggling
    always @(negedge clk_sys) begin
        if (took || !adc_valid) begin
            adc_valid <= go_s;
            adc_data <= go_s ? (neg ? -amp_s : amp_s) : ~adc_data;
            if (go_s) neg <= neg ^ alt_s;
        end
    end
endmodule // adc_source
`default_nettype wire

// file: bench/adc_record_path_processing_tb.sv
// testbench of the record path block
`timescale 1ns/1ps
`default_nettype none
module adc_record_path_processing_tb;
    logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, rec_ready = 1'b0;
    logic go = 1'b0, alt = 1'b0, adc_valid, adc_ready, rec_valid;
    logic [6:0] reg_addr = 7'h0;
    logic [8:0] reg_wdata = 9'h0, reg_rdata;
    logic [23:0] amp = 24'h0, adc_data, rec_data, last;
    logic [5:0] preamp_gain;
    int n_fail = 0, num_checks = 0, ntake = 0;
    initial forever #10 clk_sys = ~clk_sys;
    // rate code 0 weights each sample as one 48 kHz sample
    adc_record_path_processing dut (.clk_sys, .rstn, .reg_wr, .reg_addr,
        .reg_wdata, .reg_rdata, .sample_rate_code(3'h0), .boost_on(1'b0),
        .adc_data, .adc_valid, .adc_ready, .rec_data, .rec_valid,
        .rec_ready, .preamp_gain);
    adc_source src (.clk_sys, .go, .amp, .alt, .adc_ready, .adc_data,
        .adc_valid);
    always @(posedge clk_sys) begin
        if (rec_valid && rec_ready) last <= rec_data;
        if (adc_valid && adc_ready) ntake++;
    end
    task chk(input logic [23:0] g, input logic [23:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task wr(input logic [6:0] a, input logic [8:0] d);
        @(negedge clk_sys) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk_sys) reg_wr = 1'b0;
    endtask
    task run(input int n, input logic [23:0] a, input logic al);
        @(negedge clk_sys) {amp, alt, go, rec_ready} = {a, al, 2'b11};
        repeat (n + 1) @(negedge clk_sys);
        while (ntake % n != 0) @(negedge clk_sys);
        go = 1'b0;
        repeat (6) @(negedge clk_sys);
    endtask
    task t_reset;
        logic [6:0] a[7] = '{7'h0E, 7'h0F, 7'h1B, 7'h20, 7'h21, 7'h22, 7'h00};
        logic [8:0] e[7] = '{9'h100, 9'h0FF, 9'h0, 9'h038, 9'h00B, 9'h032, 9'h0};
        for (int i = 0; i < 7; i++) begin
            @(negedge clk_sys) reg_addr = a[i];
            @(negedge clk_sys) chk(reg_rdata, e[i], "reset value");
        end
        chk(preamp_gain, 6'h10, "preamp reset");
        $display("test reset done");
    endtask
    task t_path;
        wr(7'h0E, 9'h000);
        run(20, 24'h123456, 1'b0);
        chk(last, 24'h123456, "bypass");
        wr(7'h0F, 9'h000);
        run(4, 24'h123456, 1'b0);
        chk(last, 24'h0, "mute");
        wr(7'h0F, 9'h0FF);
        wr(7'h0E, 9'h100);
        run(300, 24'h100000, 1'b0);
        chk($signed(last) > 24'sh080000, 1, "audio corner");
        wr(7'h0E, 9'h180);
        run(300, 24'h100000, 1'b0);
        chk($signed(last) + 24'sh1000 < 24'sh2000, 1, "app corner");
        $display("test path done");
    endtask
    task t_fifo(input logic [6:0] a, input logic [8:0] d,
                input logic [23:0] e);
        int k;
        wr(7'h0E, 9'h000);
        run(8, 24'h0, 1'b0);
        wr(a, d);
        amp = 24'h200000;
        @(negedge clk_sys) {rec_ready, go, k} = {2'b01, ntake};
        repeat (14) @(negedge clk_sys);
        go = 1'b0;
        chk(ntake - k, 8, "fifo depth");
        chk(adc_ready, 0, "full refuses");
        chk(rec_data, e, "notch head");
        rec_ready = 1'b1;
        repeat (12) @(negedge clk_sys);
        chk(rec_valid, 0, "drained");
        $display("test fifo done");
    endtask
    task t_loop;
        wr(7'h21, 9'h000);
        wr(7'h22, 9'h100);
        wr(7'h20, 9'h138);
        run(200, 24'h7FFFFF, 1'b1);
        chk(preamp_gain < 6'h10, 1, "limiter lowers");
        run(2000, 24'h000100, 1'b1);
        chk(preamp_gain, 6'h10, "limiter restores");
        wr(7'h22, 9'h000);
        wr(7'h20, 9'h110);
        wr(7'h23, 9'h008);
        run(200, 24'h000100, 1'b1);
        chk(preamp_gain, 6'h10, "gate freezes");
        wr(7'h23, 9'h000);
        run(2000, 24'h000100, 1'b1);
        chk(preamp_gain, 6'd23, "ceiling");
        wr(7'h20, 9'h111);
        run(400, 24'h7FFFFF, 1'b1);
        chk(preamp_gain, 6'd8, "floor");
        wr(7'h20, 9'h011);
        repeat (3) @(negedge clk_sys);
        chk(preamp_gain, 6'h10, "manual gain");
        $display("test loop done");
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #2000000;
        n_fail++;
        summarize;
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rstn = 1'b1;
        t_reset;
        t_path;
        t_fifo(7'h1B, 9'h0E0, 24'h100000);
        t_fifo(7'h1C, 9'h100, 24'h180000);
        t_loop;
        summarize;
    end
endmodule // adc_record_path_processing_tb
`default_nettype wire
